//--- rtl/vbc_pkg.sv
package vbc_pkg;
	// ==========================================================
	// Register byte offsets in configuration space
	localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h06;
	localparam logic [7:0] OFS_REVISION_NUMBER = 8'h08;
	localparam logic [7:0] OFS_BRIDGE_CATEGORY_CODE = 8'h0a;
	localparam logic [7:0] OFS_CLASS_CODE_BASE = 8'h0b;
	localparam logic [7:0] OFS_LATENCY_SCRATCHPAD = 8'h0d;
	localparam logic [7:0] OFS_HEADER_LAYOUT = 8'h0e;
	localparam logic [7:0] OFS_PRIMARY_BUS_NUMBER = 8'h18;
	localparam logic [7:0] OFS_SECONDARY_BUS_NUMBER = 8'h19;
	localparam logic [7:0] OFS_SUBORDINATE_BUS_NUMBER = 8'h1a;
	// ==========================================================
	// Primary status field positions
	localparam int BIT_PARITY_ERROR_DETECTED = 15;
	localparam int BIT_SYSTEM_ERROR_SIGNALED = 14;
	localparam int BIT_MASTER_ABORT_RECEIVED = 13;
	localparam int BIT_TARGET_ABORT_RECEIVED = 12;
	localparam int BIT_TARGET_ABORT_SIGNALED = 11;
	localparam int BIT_DATA_PARITY_FLAG = 8;
	localparam int BIT_BACK_TO_BACK_CAPABLE = 7;
	localparam int BIT_FAST_CLOCK_CAPABLE = 5;
	localparam logic [1:0] DECODE_SPEED_FAST = 2'h0;
	localparam logic [15:0] PRIMARY_STATUS_RESET = 16'h00a0;
	// ==========================================================
	// Fixed identification bytes and reset values
	localparam logic [7:0] BRIDGE_CATEGORY_VALUE = 8'h04;
	localparam logic [7:0] CLASS_BASE_VALUE = 8'h06;
	localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h01;
	localparam logic [7:0] PRIMARY_BUS_VALUE = 8'h00;
	localparam logic [7:0] BUS_NUMBER_RESET = 8'h00;
	localparam logic [4:0] SCRATCH_BITS_RESET = 5'h00;
endpackage : vbc_pkg

//--- rtl/vbc_err_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vbc_err_if;
	logic message_sent;
	logic clear_req;
	logic flag;
	modport owner (input message_sent, input clear_req, output flag);
	modport user (output message_sent, output clear_req, input flag);
endinterface : vbc_err_if
`default_nettype wire

//--- rtl/vbc_sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none
module vbc_sticky_flag (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Event and clear
	vbc_err_if.owner err
);
	logic flag_reg;
	logic flag_next;

	// A message in the clear cycle keeps the flag set
	assign flag_next = err.message_sent | (flag_reg & ~err.clear_req);

	always_ff @(posedge clk_sys) begin
		if (rst)
			flag_reg <= 1'b0;
		else if (ce)
			flag_reg <= flag_next;
	end

	assign err.flag = flag_reg;

	property p_set_wins;
		@(posedge clk_sys) disable iff (rst)
		ce && err.message_sent |=> flag_reg;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("flag missed event");

	property p_clear_only;
		@(posedge clk_sys) disable iff (rst)
		ce && err.clear_req && !err.message_sent |=> !flag_reg;
	endproperty
	a_clear_only: assert property (p_clear_only)
		else $error("flag not cleared");
endmodule : vbc_sticky_flag
`default_nettype wire

//--- rtl/vbc_config_header.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Parity bits 15 and 8 read zero
// - Bit 14 sets when error message sent
// - Error flag clears on write one only
// - Master abort bit 13 reads zero
// - Target abort bits 12, 11 read zero
// - Decode speed bits 10:9 read 00
// - Bit 7 back-to-back reads one
// - Bit 5 fast clock reads one
// - Revision mirrors main function revision
// - Category byte reads 04h
// - Class base byte reads 06h
// - Latency bits 7:3 scratchpad, 2:0 reserved
// - Header layout byte reads 01
// - Primary bus number fixed zero
// - Secondary bus number writable, resets 00h
// - Subordinate bus number writable byte
// - No message unless message enable set
module vbc_config_header (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Configuration access, byte addressed, one byte per access
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output logic cfg_hit,
	// Error side
	input wire logic [7:0] main_revision_number,
	input wire logic error_message_enable,
	input wire logic error_condition,
	output logic error_message,
	output logic system_error_signaled,
	// Bus steering
	output logic [7:0] secondary_bus_field,
	output logic [7:0] subordinate_field
);
	// ==========================================================
	// Storage
	logic [4:0] scratch_bits_reg;
	logic [7:0] secondary_bus_reg;
	logic [7:0] subordinate_reg;
	logic [7:0] rdata_reg;
	logic hit_reg;
	logic msg_reg;
	vbc_err_if err ();

	// ==========================================================
	// Decode
	wire wr_en = ce & cfg_wr;
	wire sel_sts_lo = cfg_addr == vbc_pkg::OFS_PRIMARY_STATUS;
	wire sel_sts_hi = cfg_addr == (vbc_pkg::OFS_PRIMARY_STATUS + 8'h01);
	wire sel_rev = cfg_addr == vbc_pkg::OFS_REVISION_NUMBER;
	wire sel_cat = cfg_addr == vbc_pkg::OFS_BRIDGE_CATEGORY_CODE;
	wire sel_cls = cfg_addr == vbc_pkg::OFS_CLASS_CODE_BASE;
	wire sel_lat = cfg_addr == vbc_pkg::OFS_LATENCY_SCRATCHPAD;
	wire sel_hdr = cfg_addr == vbc_pkg::OFS_HEADER_LAYOUT;
	wire sel_pbus = cfg_addr == vbc_pkg::OFS_PRIMARY_BUS_NUMBER;
	wire sel_sbus = cfg_addr == vbc_pkg::OFS_SECONDARY_BUS_NUMBER;
	wire sel_sub = cfg_addr == vbc_pkg::OFS_SUBORDINATE_BUS_NUMBER;
	wire any_sel = sel_sts_lo | sel_sts_hi | sel_rev | sel_cat | sel_cls | sel_lat
		| sel_hdr | sel_pbus | sel_sbus | sel_sub;

	// Only bit 14 of the high status byte has a write effect
	wire clear_req = wr_en & sel_sts_hi & cfg_wdata[vbc_pkg::BIT_SYSTEM_ERROR_SIGNALED - 8];

	// Message is gated by the command-register enable
	wire message_fire = error_condition & error_message_enable;

	assign err.message_sent = msg_reg;
	assign err.clear_req = clear_req;

	vbc_sticky_flag u_flag (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.err(err)
	);

	// ==========================================================
	// Assembled read values
	logic [15:0] status_word;
	always_comb begin
		status_word = 16'h0000;
		status_word[vbc_pkg::BIT_SYSTEM_ERROR_SIGNALED] = err.flag;
		status_word[10:9] = vbc_pkg::DECODE_SPEED_FAST;
		status_word[vbc_pkg::BIT_BACK_TO_BACK_CAPABLE] = 1'b1;
		status_word[vbc_pkg::BIT_FAST_CLOCK_CAPABLE] = 1'b1;
	end

	wire [7:0] lat_byte = {scratch_bits_reg, 3'h0};
	wire [7:0] read_mux =
		sel_sts_lo ? status_word[7:0] :
		sel_sts_hi ? status_word[15:8] :
		sel_rev ? main_revision_number :
		sel_cat ? vbc_pkg::BRIDGE_CATEGORY_VALUE :
		sel_cls ? vbc_pkg::CLASS_BASE_VALUE :
		sel_lat ? lat_byte :
		sel_hdr ? vbc_pkg::HEADER_LAYOUT_VALUE :
		sel_pbus ? vbc_pkg::PRIMARY_BUS_VALUE :
		sel_sbus ? secondary_bus_reg :
		sel_sub ? subordinate_reg :
		8'h00;

	// ==========================================================
	// Writable fields
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scratch_bits_reg <= vbc_pkg::SCRATCH_BITS_RESET;
			secondary_bus_reg <= vbc_pkg::BUS_NUMBER_RESET;
			subordinate_reg <= vbc_pkg::BUS_NUMBER_RESET;
		end else if (wr_en) begin
			if (sel_lat)
				scratch_bits_reg <= cfg_wdata[7:3];
			if (sel_sbus)
				secondary_bus_reg <= cfg_wdata;
			if (sel_sub)
				subordinate_reg <= cfg_wdata;
		end
	end

	// ==========================================================
	// Read port and registered outputs
	// Revision goes straight to the read flop, so the first read after reset mirrors it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			hit_reg <= 1'b0;
			msg_reg <= 1'b0;
		end else if (ce) begin
			rdata_reg <= cfg_rd ? read_mux : 8'h00;
			hit_reg <= (cfg_rd | cfg_wr) & any_sel;
			msg_reg <= message_fire;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_hit = hit_reg;
	assign error_message = msg_reg;
	assign system_error_signaled = err.flag;
	assign secondary_bus_field = secondary_bus_reg;
	assign subordinate_field = subordinate_reg;

	// ==========================================================
	// Checks: message gating and the sticky flag
	// All checks run on the register clock and are quiet while reset is held
	property p_no_msg_disabled;
		@(posedge clk_sys) disable iff (rst)
		ce && !error_message_enable |=> !msg_reg;
	endproperty
	a_no_msg_disabled: assert property (p_no_msg_disabled)
		else $error("message while disabled");

	property p_msg_enabled;
		@(posedge clk_sys) disable iff (rst)
		ce && error_condition && error_message_enable |=> msg_reg;
	endproperty
	a_msg_enabled: assert property (p_msg_enabled)
		else $error("message missing");

	property p_msg_sets_flag;
		@(posedge clk_sys) disable iff (rst)
		ce && msg_reg |=> system_error_signaled;
	endproperty
	a_msg_sets_flag: assert property (p_msg_sets_flag)
		else $error("flag not set");

	property p_clear;
		@(posedge clk_sys) disable iff (rst)
		ce && clear_req && !msg_reg |=> !system_error_signaled;
	endproperty
	a_clear: assert property (p_clear)
		else $error("flag not cleared");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		system_error_signaled && !clear_req |=> system_error_signaled;
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag dropped");

	// Software may write the whole high byte; only a one in the flag bit may clear
	property p_write_zero;
		@(posedge clk_sys) disable iff (rst)
		wr_en && sel_sts_hi && !cfg_wdata[vbc_pkg::BIT_SYSTEM_ERROR_SIGNALED - 8] && !msg_reg
			|=> $stable(system_error_signaled);
	endproperty
	a_write_zero: assert property (p_write_zero)
		else $error("flag changed by a zero write");

	// ==========================================================
	// Checks: fixed and mirrored read bytes
	property p_sts_lo;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_sts_lo |=> cfg_rdata == 8'ha0;
	endproperty
	a_sts_lo: assert property (p_sts_lo)
		else $error("status low wrong");

	// Bit 6 of the high byte is the flag as it stood when the read was taken
	property p_sts_hi;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_sts_hi |=> cfg_rdata[7] == 1'b0 && cfg_rdata[5:0] == 6'h00
			&& cfg_rdata[6] == $past(system_error_signaled);
	endproperty
	a_sts_hi: assert property (p_sts_hi)
		else $error("status high wrong");

	property p_cat;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_cat |=> cfg_rdata == 8'h04;
	endproperty
	a_cat: assert property (p_cat)
		else $error("category byte wrong");

	property p_cls;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_cls |=> cfg_rdata == 8'h06;
	endproperty
	a_cls: assert property (p_cls)
		else $error("class byte wrong");

	property p_hdr;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_hdr |=> cfg_rdata == 8'h01;
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header layout byte wrong");

	property p_pbus;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_pbus |=> cfg_rdata == 8'h00;
	endproperty
	a_pbus: assert property (p_pbus)
		else $error("primary bus byte wrong");

	// No revision copy is kept here; a read shows the input as it stood
	property p_rev;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_rev |=> cfg_rdata == $past(main_revision_number);
	endproperty
	a_rev: assert property (p_rev)
		else $error("revision not mirrored");

	property p_lat_low;
		@(posedge clk_sys) disable iff (rst)
		ce && cfg_rd && sel_lat |=> cfg_rdata[2:0] == 3'h0;
	endproperty
	a_lat_low: assert property (p_lat_low)
		else $error("latency reserved bits set");

	property p_unmapped;
		@(posedge clk_sys) disable iff (rst)
		ce && (cfg_rd || cfg_wr) && !any_sel |=> !cfg_hit && cfg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped offset answered");

	// ==========================================================
	// Checks: writable fields and the clock enable
	property p_sbus_write;
		@(posedge clk_sys) disable iff (rst)
		wr_en && sel_sbus |=> secondary_bus_field == $past(cfg_wdata);
	endproperty
	a_sbus_write: assert property (p_sbus_write)
		else $error("secondary bus not stored");

	property p_sub_write;
		@(posedge clk_sys) disable iff (rst)
		wr_en && sel_sub |=> subordinate_field == $past(cfg_wdata);
	endproperty
	a_sub_write: assert property (p_sub_write)
		else $error("subordinate bus not stored");

	property p_lat_write;
		@(posedge clk_sys) disable iff (rst)
		wr_en && sel_lat |=> scratch_bits_reg == $past(cfg_wdata[7:3]);
	endproperty
	a_lat_write: assert property (p_lat_write)
		else $error("scratch bits not stored");

	// A low enable must freeze the bus fields, the read data and the flag
	property p_freeze;
		@(posedge clk_sys) disable iff (rst)
		!ce |=> $stable(secondary_bus_field) && $stable(subordinate_field)
			&& $stable(cfg_rdata) && $stable(system_error_signaled);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while disabled");

	c_msg: cover property (@(posedge clk_sys) disable iff (rst) msg_reg ##1 system_error_signaled);
	c_clear: cover property (@(posedge clk_sys) disable iff (rst)
		system_error_signaled ##1 !system_error_signaled);
	c_race: cover property (@(posedge clk_sys) disable iff (rst) clear_req && msg_reg);
	c_sub: cover property (@(posedge clk_sys) disable iff (rst) wr_en && sel_sub);
	c_frozen_write: cover property (@(posedge clk_sys) disable iff (rst) !ce && cfg_wr);
endmodule : vbc_config_header
`default_nettype wire

//--- test/vbc_config_header_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// One compare macro, so every check counts and reports alike
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
	$display("Error %s expected %h seen %h", what, exp, got); end end
module vbc_config_header_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cfg_rd = 1'b0;
	logic cfg_wr = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [7:0] cfg_wdata = 8'h00;
	// Arbitrary revision value; check_defaults expects this same byte, 8'h3c, at offset 08h
	logic [7:0] main_revision_number = 8'h3c;
	logic error_message_enable = 1'b0;
	logic error_condition = 1'b0;
	logic [7:0] cfg_rdata;
	logic cfg_hit;
	logic error_message;
	logic system_error_signaled;
	logic [7:0] secondary_bus_field;
	logic [7:0] subordinate_field;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	vbc_config_header vbc_config_header_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .main_revision_number(main_revision_number),
		.error_message_enable(error_message_enable), .error_condition(error_condition),
		.error_message(error_message), .system_error_signaled(system_error_signaled),
		.secondary_bus_field(secondary_bus_field), .subordinate_field(subordinate_field));
	always #10 clk_sys = ~clk_sys;
	// ==========================================================
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// ==========================================================
	// Bus cycles: request held for one taken edge, answer looked at the cycle after
	task rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
		@(posedge clk_sys);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		`CHK("read data", exp, cfg_rdata);
		`CHK("read hit", h, cfg_hit);
	endtask : rd
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		#1;
	endtask : wr
	task pulse(input logic en, input logic exp_msg);
		@(posedge clk_sys);
		error_message_enable <= en;
		error_condition <= 1'b1;
		@(posedge clk_sys);
		error_condition <= 1'b0;
		#1;
		`CHK("error message", exp_msg, error_message);
	endtask : pulse
	// ==========================================================
	// Scenarios
	task check_defaults;
		rd(8'h06, 8'ha0, 1'b1);
		rd(8'h07, 8'h00, 1'b1);
		rd(8'h08, 8'h3c, 1'b1);
		rd(8'h0a, 8'h04, 1'b1);
		rd(8'h0b, 8'h06, 1'b1);
		rd(8'h0d, 8'h00, 1'b1);
		rd(8'h0e, 8'h01, 1'b1);
		rd(8'h18, 8'h00, 1'b1);
		rd(8'h19, 8'h00, 1'b1);
		rd(8'h1a, 8'h00, 1'b1);
		rd(8'h30, 8'h00, 1'b0);
	endtask : check_defaults
	task t_read_only;
		wr(8'h06, 8'hff);
		wr(8'h07, 8'hbf);
		wr(8'h08, 8'hff);
		wr(8'h0a, 8'hff);
		wr(8'h0b, 8'hff);
		wr(8'h0e, 8'hff);
		wr(8'h18, 8'hff);
		wr(8'h30, 8'hff);
		check_defaults();
		$display("test read_only done");
	endtask : t_read_only
	task t_scratch;
		wr(8'h0d, 8'hff);
		rd(8'h0d, 8'hf8, 1'b1);
		wr(8'h0d, 8'h57);
		rd(8'h0d, 8'h50, 1'b1);
		$display("test scratch done");
	endtask : t_scratch
	task t_bus;
		wr(8'h19, 8'h05);
		`CHK("write hit", 1'b1, cfg_hit);
		`CHK("secondary field", 8'h05, secondary_bus_field);
		wr(8'h1a, 8'h09);
		`CHK("subordinate field", 8'h09, subordinate_field);
		@(posedge clk_sys);
		ce <= 1'b0;
		cfg_wr <= 1'b1;
		cfg_addr <= 8'h19;
		cfg_wdata <= 8'hee;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		ce <= 1'b1;
		rd(8'h19, 8'h05, 1'b1);
		rd(8'h1a, 8'h09, 1'b1);
		$display("test bus done");
	endtask : t_bus
	task t_error;
		pulse(1'b0, 1'b0);
		rd(8'h07, 8'h00, 1'b1);
		pulse(1'b1, 1'b1);
		rd(8'h07, 8'h40, 1'b1);
		`CHK("flag port", 1'b1, system_error_signaled);
		wr(8'h07, 8'hbf);
		rd(8'h07, 8'h40, 1'b1);
		wr(8'h07, 8'h40);
		rd(8'h07, 8'h00, 1'b1);
		`CHK("flag port", 1'b0, system_error_signaled);
		$display("test error done");
	endtask : t_error
	// Message and clear land on one edge: the set must win
	task t_race;
		@(posedge clk_sys);
		error_message_enable <= 1'b1;
		error_condition <= 1'b1;
		@(posedge clk_sys);
		error_condition <= 1'b0;
		cfg_wr <= 1'b1;
		cfg_addr <= 8'h07;
		cfg_wdata <= 8'h40;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		#1;
		`CHK("set over clear", 1'b1, system_error_signaled);
		wr(8'h07, 8'h40);
		`CHK("flag port", 1'b0, system_error_signaled);
		$display("test race done");
	endtask : t_race
	task t_reset_again;
		wr(8'h19, 8'h7a);
		wr(8'h1a, 8'h7b);
		wr(8'h0d, 8'hff);
		pulse(1'b1, 1'b1);
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK("flag after reset", 1'b0, system_error_signaled);
		check_defaults();
		$display("test reset_again done");
	endtask : t_reset_again
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		check_defaults();
		$display("test defaults done");
		t_read_only();
		t_scratch();
		t_bus();
		t_error();
		t_race();
		t_reset_again();
		summarize();
	end
endmodule : vbc_config_header_bench
`default_nettype wire
